// ---- core/rfg_regfile.sv ----
// rfg_regfile: 32x8 working register file, pointer unit, shared temp
// byte for 16-bit peripheral access, and config change guard.
// assumes a pipeline that issues one operation per cycle on clk.
`timescale 1ns/100ps
module rfg_regfile
   import rfg_pkg::*;
#(
   parameter int NREGS = NUM_REGS
)(
   input wire logic clk,
   input wire logic rst,
   // read ports
   input wire logic [4:0] rd_a_idx,          // first operand index
   input wire logic [4:0] rd_b_idx,          // second operand index
   input wire logic rd_word,                 // a is a 16-bit pair read
   // write port
   input wire rfg_wr_mode_t wr_mode,         // none, byte, word
   input wire logic [4:0] wr_idx,            // destination (even for word)
   input wire logic [15:0] wr_data,          // result
   // pointer unit
   input wire logic ptr_req,                 // data load/store via pointer
   input wire logic prog_req,                // program load / indirect jump
   input wire rfg_ptr_sel_t ptr_sel,         // which pointer
   input wire rfg_addr_mode_t ptr_mode,      // addressing variant
   input wire logic [5:0] ptr_disp,          // displacement
   // 16-bit peripheral byte access through the temp byte
   input wire logic pio_wr,                  // peripheral byte write
   input wire logic pio_rd,                  // peripheral byte read
   input wire logic pio_hi,                  // high byte selected
   input wire logic [7:0] pio_wdata,         // byte written
   input wire logic [15:0] pio_cur,          // current peripheral value
   input wire logic tmp_wr,                  // direct temp write
   input wire logic tmp_rd,                  // direct temp read
   // guard
   input wire logic key_wr,
   input wire logic [7:0] key_data,
   input wire logic insn_done,
   input wire logic io_or_mem_wr,
   input wire logic nvm_access,
   input wire logic sleep_exec,
   input wire logic irq_pending,             // any request flag set
   // outputs, all registered
   output logic [7:0] rd_a_data,
   output logic [7:0] rd_b_data,
   output logic [15:0] rd_word_data,
   output logic [15:0] addr_out,             // effective address
   output logic addr_valid,
   output logic addr_is_prog,                // address for program space
   output logic pio_commit,                  // 16-bit write strobe
   output logic [15:0] pio_commit_data,      // full word to commit
   output logic [7:0] pio_rdata,             // peripheral read byte
   output logic irq_take_ok,                 // interrupts may be taken
   output logic io_unprotect_key,            // io window open
   output logic self_program_unlock,         // self-program window open
   output logic [7:0] config_change_guard    // guard register read value
);
   import rfg_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state: the struct holds every flip-flop of this module
   typedef struct packed {
      logic [NREGS-1:0][7:0] gpr;
      logic [7:0] tmp;
      logic [7:0] rd_a;
      logic [7:0] rd_b;
      logic [15:0] rd_w;
      logic [15:0] addr;
      logic addr_v;
      logic addr_p;
      logic commit;
      logic [15:0] commit_d;
      logic [7:0] prd;
      logic irq_ok;
      logic io_o;
      logic sp_o;
      logic [7:0] guard;
   } rfg_st_t;
   rfg_st_t st_reg, st_next;

   logic g_io, g_sp;        // live guard windows
   logic [7:0] g_status;    // guard read value

   // low index of a pointer pair
   function automatic logic [4:0] ptr_lo(input rfg_ptr_sel_t s);
      case (s)
         RFG_PTR_X: ptr_lo = PTR_X_LO;
         RFG_PTR_Y: ptr_lo = PTR_Y_LO;
         default: ptr_lo = PTR_Z_LO;
      endcase
   endfunction : ptr_lo

   // read a register pair as a 16-bit value
   function automatic logic [15:0] pair(input rfg_st_t s,
                                       input logic [4:0] lo);
      pair = {s.gpr[lo | 5'h01], s.gpr[lo & 5'h1e]};
   endfunction : pair

   ////////////////////////////////////////////////////////////////////
   // guard unit
   rfg_guard u_guard (
      .clk(clk),
      .rst(rst),
      .key_wr(key_wr),
      .key_data(key_data),
      .insn_done(insn_done),
      .io_or_mem_wr(io_or_mem_wr),
      .nvm_access(nvm_access),
      .sleep_exec(sleep_exec),
      .io_open(g_io),
      .sp_open(g_sp),
      .status(g_status)
   );

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [4:0] plo;
      logic [15:0] pv;
      logic [15:0] pupd;
      logic upd;
      plo = 5'h00;
      pv = 16'h0000;
      pupd = 16'h0000;
      upd = 1'b0;
      st_next = st_reg;
      // reads see registers only; data space cannot reach them
      st_next.rd_a = st_reg.gpr[rd_a_idx];
      st_next.rd_b = st_reg.gpr[rd_b_idx];
      st_next.rd_w = rd_word ? pair(st_reg, rd_a_idx) : 16'h0000;
      // pointer address generation
      st_next.addr_v = 1'b0;
      st_next.addr_p = 1'b0;
      if (prog_req) begin
         // program space only ever uses the third pointer
         plo = PTR_Z_LO;
      end else begin
         plo = ptr_lo(ptr_sel);
      end
      pv = pair(st_reg, plo);
      if (ptr_req || prog_req) begin
         st_next.addr_v = 1'b1;
         st_next.addr_p = prog_req;
         case (ptr_mode)
            RFG_AM_DISP: begin
               st_next.addr = pv + {10'h000, ptr_disp};
            end
            RFG_AM_POSTINC: begin
               st_next.addr = pv;
               pupd = pv + 16'h0001;
               upd = 1'b1;
            end
            RFG_AM_PREDEC: begin
               pupd = pv - 16'h0001;
               st_next.addr = pupd;
               upd = 1'b1;
            end
            default: st_next.addr = pv;
         endcase
      end
      // result write-back; word writes land on an even pair
      case (wr_mode)
         RFG_WR_BYTE: st_next.gpr[wr_idx] = wr_data[7:0];
         RFG_WR_WORD: begin
            st_next.gpr[wr_idx & 5'h1e] = wr_data[7:0];
            st_next.gpr[wr_idx | 5'h01] = wr_data[15:8];
         end
         default: ;
      endcase
      // pointer update after write-back, so auto-modify wins a clash
      if (upd) begin
         st_next.gpr[plo] = pupd[7:0];
         st_next.gpr[plo | 5'h01] = pupd[15:8];
      end
      // atomic 16-bit access via the shared temp byte
      st_next.commit = 1'b0;
      st_next.prd = 8'h00;
      if (pio_wr) begin
         if (!pio_hi) begin
            st_next.tmp = pio_wdata;
         end else begin
            st_next.commit = 1'b1;
            st_next.commit_d = {pio_wdata, st_reg.tmp};
         end
      end else if (pio_rd) begin
         if (!pio_hi) begin
            st_next.prd = pio_cur[7:0];
            st_next.tmp = pio_cur[15:8];
         end else begin
            st_next.prd = st_reg.tmp;
         end
      end else if (tmp_wr) begin
         st_next.tmp = pio_wdata;
      end else if (tmp_rd) begin
         st_next.prd = st_reg.tmp;
      end
      // hold off interrupts while either window runs; flags stay pending
      // outside, so they are served as soon as this rises again
      st_next.irq_ok = !(g_io || g_sp) && irq_pending;
      st_next.io_o = g_io;
      st_next.sp_o = g_sp;
      st_next.guard = g_status;
   end

   // register the state; register file contents clear at reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) st_reg <= '0;
      else st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign rd_a_data = st_reg.rd_a;
   assign rd_b_data = st_reg.rd_b;
   assign rd_word_data = st_reg.rd_w;
   assign addr_out = st_reg.addr;
   assign addr_valid = st_reg.addr_v;
   assign addr_is_prog = st_reg.addr_p;
   assign pio_commit = st_reg.commit;
   assign pio_commit_data = st_reg.commit_d;
   assign pio_rdata = st_reg.prd;
   assign irq_take_ok = st_reg.irq_ok;
   assign io_unprotect_key = st_reg.io_o;
   assign self_program_unlock = st_reg.sp_o;
   assign config_change_guard = st_reg.guard;
endmodule : rfg_regfile

// ---- core/rfg_pkg.sv ----
// rfg_pkg: constants shared by the register file / atomic guard block.
// assumes a single cpu clock; no software-visible bus of its own.
package rfg_pkg;
   localparam int NUM_REGS = 32;             // working registers
   localparam int DATA_W = 8;                // byte width
   localparam int IDX_W = 5;                 // register index width
   localparam int PTR_W = 16;                // pointer width
   localparam logic [4:0] PTR_X_LO = 5'h1a;  // first pointer low byte
   localparam logic [4:0] PTR_Y_LO = 5'h1c;  // second pointer low byte
   localparam logic [4:0] PTR_Z_LO = 5'h1e;  // third pointer low byte
   localparam logic [7:0] SIG_SELF_PROG = 8'h9d; // self-program key
   localparam logic [7:0] SIG_IO = 8'hd8;        // protected io key
   localparam logic [2:0] UNLOCK_INSNS = 3'h4;   // window in instructions
   localparam int GUARD_IO_BIT = 0;          // status bit: io window
   localparam int GUARD_SP_BIT = 1;          // status bit: self-program
   // write-port modes
   typedef enum logic [1:0] {
      RFG_WR_NONE,
      RFG_WR_BYTE,
      RFG_WR_WORD
   } rfg_wr_mode_t;
   // pointer selection
   typedef enum logic [1:0] {
      RFG_PTR_X,
      RFG_PTR_Y,
      RFG_PTR_Z
   } rfg_ptr_sel_t;
   // pointer addressing variant
   typedef enum logic [1:0] {
      RFG_AM_PLAIN,
      RFG_AM_DISP,
      RFG_AM_POSTINC,
      RFG_AM_PREDEC
   } rfg_addr_mode_t;
endpackage : rfg_pkg

// ---- core/rfg_guard.sv ----
// rfg_guard: configuration change guard with two unlock windows.
// assumes the pipeline pulses insn_done once per retired instruction.
`timescale 1ns/100ps
module rfg_guard
   import rfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic key_wr,          // write to config_change_guard
   input wire logic [7:0] key_data,  // written value
   input wire logic insn_done,       // one instruction retired
   input wire logic io_or_mem_wr,    // cpu write to io or data memory
   input wire logic nvm_access,      // flash/nvm ctrl/eeprom load/store
   input wire logic sleep_exec,      // sleep instruction
   output logic io_open,             // io_unprotect_key window open
   output logic sp_open,             // self_program_unlock window open
   output logic [7:0] status         // read value of guard register
);
   import rfg_pkg::*;
   // whole state in one struct
   typedef struct packed {
      logic io_open;
      logic sp_open;
      logic [2:0] io_cnt;
      logic [2:0] sp_cnt;
   } rfg_guard_st_t;
   rfg_guard_st_t st_reg, st_next;

   ////////////////////////////////////////////////////////////////////
   // next state: the key decode comes after the kill terms and overrides them
   // for the window it opens, since that write is also an io write
   always_comb begin
      st_next = st_reg;
      // io window countdown and kill
      if (st_reg.io_open) begin
         if (io_or_mem_wr || nvm_access || sleep_exec) begin
            st_next.io_open = 1'b0;
         end else if (insn_done) begin
            st_next.io_cnt = st_reg.io_cnt - 3'h1;
            if (st_reg.io_cnt == 3'h1) st_next.io_open = 1'b0;
         end
      end
      // self-program window countdown and kill
      if (st_reg.sp_open) begin
         if (nvm_access || sleep_exec) begin
            st_next.sp_open = 1'b0;
         end else if (insn_done) begin
            st_next.sp_cnt = st_reg.sp_cnt - 3'h1;
            if (st_reg.sp_cnt == 3'h1) st_next.sp_open = 1'b0;
         end
      end
      // key decode; other values open nothing
      if (key_wr) begin
         if (key_data == SIG_IO) begin
            st_next.io_open = 1'b1;
            st_next.io_cnt = UNLOCK_INSNS;
         end else if (key_data == SIG_SELF_PROG) begin
            st_next.sp_open = 1'b1;
            st_next.sp_cnt = UNLOCK_INSNS;
         end
      end
   end

   // register the state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) st_reg <= '0;
      else st_reg <= st_next;
   end

   assign io_open = st_reg.io_open;
   assign sp_open = st_reg.sp_open;
   // upper bits always zero
   always_comb begin
      status = 8'h00;
      status[GUARD_IO_BIT] = st_reg.io_open;
      status[GUARD_SP_BIT] = st_reg.sp_open;
   end
endmodule : rfg_guard

// ---- sim/rfg_regfile_props.sv ----
// rfg_regfile_props: port checks for the register file and the guard.
// assumes it is bound onto rfg_regfile, one clock domain.
`timescale 1ns/100ps
module rfg_regfile_props
   import rfg_pkg::*;
(
   input wire logic clk, rst, key_wr, io_or_mem_wr, nvm_access,
   input wire logic sleep_exec, ptr_req, prog_req, pio_wr, pio_rd,
   input wire logic pio_hi, addr_valid, addr_is_prog, pio_commit,
   input wire logic irq_take_ok, io_unprotect_key, self_program_unlock,
   input wire logic [7:0] key_data, pio_wdata, pio_rdata,
   input wire logic [7:0] config_change_guard,
   input wire logic [15:0] pio_cur, pio_commit_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // guard register view and interrupt hold-off
   property p_guard_rd;
      config_change_guard == {6'h0, self_program_unlock, io_unprotect_key};
   endproperty
   a_guard_rd: assert property (p_guard_rd) else $error("guard read");
   property p_no_irq;
      io_unprotect_key || self_program_unlock |-> !irq_take_ok;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("irq in window");
   // windows open two edges after the key, the io one only after its key
   property p_io_open; key_wr && key_data == SIG_IO |-> ##2 io_unprotect_key;
   endproperty
   a_io_open: assert property (p_io_open) else $error("io shut");
   property p_sp_open;
      key_wr && key_data == SIG_SELF_PROG |-> ##2 self_program_unlock;
   endproperty
   a_sp_open: assert property (p_sp_open) else $error("sp shut");
   property p_cause;
      $rose(io_unprotect_key) |-> $past(key_data, 2) == SIG_IO;
   endproperty
   a_cause: assert property (p_cause) else $error("io opened wrongly");
   // kill events end the window; a key for that window in the same cycle wins
   property p_io_kill; io_unprotect_key && !key_wr &&
      (io_or_mem_wr || nvm_access || sleep_exec) |-> ##2 !io_unprotect_key;
   endproperty
   a_io_kill: assert property (p_io_kill) else $error("io kept");
   property p_sp_kill; self_program_unlock && !key_wr &&
      (nvm_access || sleep_exec) |-> ##2 !self_program_unlock;
   endproperty
   a_sp_kill: assert property (p_sp_kill) else $error("sp kept");
   ////////////////////////////////////////////////////////////////////////
   // temp byte sequences, pointer address check and covers
   property p_commit; pio_wr && !pio_hi ##1 pio_wr && pio_hi |-> ##1
      pio_commit && pio_commit_data == {$past(pio_wdata), $past(pio_wdata, 2)};
   endproperty
   a_commit: assert property (p_commit) else $error("bad commit");
   property p_rd_hi; pio_rd && !pio_hi ##1 pio_rd && pio_hi |-> ##1
      {8'h00, pio_rdata} == $past(pio_cur, 2) >> 8;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("torn read");
   property p_addr;
      ptr_req || prog_req |-> ##1 addr_valid && addr_is_prog == $past(prog_req);
   endproperty
   a_addr: assert property (p_addr) else $error("no address");
   c_io: cover property (key_wr && key_data == SIG_IO ##2 io_unprotect_key);
   c_commit: cover property (pio_commit);
   c_prog: cover property (addr_valid && addr_is_prog);
endmodule : rfg_regfile_props
bind rfg_regfile rfg_regfile_props i_rfg_regfile_props (.clk, .rst, .key_wr,
   .io_or_mem_wr, .nvm_access, .sleep_exec, .ptr_req, .prog_req, .pio_wr,
   .pio_rd, .pio_hi, .addr_valid, .addr_is_prog, .pio_commit, .irq_take_ok,
   .io_unprotect_key, .self_program_unlock, .key_data, .pio_wdata,
   .pio_rdata, .config_change_guard, .pio_cur, .pio_commit_data);

// ---- sim/rfg_periph_model.sv ----
// rfg_periph_model: a 16-bit peripheral register behind the temp byte.
// assumes commits come from the block; the bench may overwrite it.
`timescale 1ns/100ps
module rfg_periph_model (
   input wire logic clk, rst, pio_commit, upd,
   input wire logic [15:0] pio_commit_data, upd_val,
   output logic [15:0] pio_cur
);
   // the word only ever moves whole, never one byte at a time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pio_cur <= 16'h0000;
      end else if (pio_commit) begin
         pio_cur <= pio_commit_data;
      end else if (upd) begin
         pio_cur <= upd_val; // hardware side changing the live value
      end
   end
endmodule : rfg_periph_model

// ---- sim/tb_top.sv ----
// tb_top: self-checking bench for rfg_regfile and a peripheral model.
// assumes the package, design, checker and model are compiled first.
`timescale 1ns/100ps
module tb_top;
   import rfg_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] rd_a_idx, rd_b_idx, wr_idx;
   logic rd_word, ptr_req, prog_req, pio_wr, pio_rd, pio_hi, tmp_wr, tmp_rd;
   logic key_wr, insn_done, io_or_mem_wr, nvm_access, sleep_exec;
   logic irq_pending, upd, addr_valid, addr_is_prog, pio_commit;
   logic irq_take_ok, io_unprotect_key, self_program_unlock;
   logic [15:0] wr_data, pio_cur, upd_val, rd_word_data, addr_out;
   logic [15:0] pio_commit_data, pexp;
   logic [7:0] pio_wdata, key_data, rd_a_data, rd_b_data, pio_rdata;
   logic [7:0] config_change_guard;
   logic [5:0] ptr_disp;
   rfg_wr_mode_t wr_mode;
   rfg_ptr_sel_t ptr_sel;
   rfg_addr_mode_t ptr_mode;
   logic [7:0] m [32]; // mirror of the working registers
   int n_mismatch = 0;
   int compares = 0;
   always #2.5 clk = ~clk;
   rfg_regfile i_rfg_regfile (.clk, .rst, .rd_a_idx, .rd_b_idx, .rd_word,
      .wr_mode, .wr_idx, .wr_data, .ptr_req, .prog_req, .ptr_sel, .ptr_mode,
      .ptr_disp, .pio_wr, .pio_rd, .pio_hi, .pio_wdata, .pio_cur, .tmp_wr,
      .tmp_rd, .key_wr, .key_data, .insn_done, .io_or_mem_wr, .nvm_access,
      .sleep_exec, .irq_pending, .rd_a_data, .rd_b_data, .rd_word_data,
      .addr_out, .addr_valid, .addr_is_prog, .pio_commit, .pio_commit_data,
      .pio_rdata, .irq_take_ok, .io_unprotect_key, .self_program_unlock,
      .config_change_guard);
   rfg_periph_model i_rfg_periph_model (.clk, .rst, .pio_commit, .upd,
      .pio_commit_data, .upd_val, .pio_cur);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   // expected pointer value from the mirror
   function automatic logic [15:0] pv(input int s);
      return {m[27 + 2 * s], m[26 + 2 * s]};
   endfunction : pv
   task automatic wr(input rfg_wr_mode_t md, input int ix);
      wr_mode = md;
      wr_idx = 5'(ix);
      wr_data = 16'($urandom);
      m[ix] = wr_data[7:0];
      if (md == RFG_WR_WORD) m[ix & 30] = wr_data[7:0];
      if (md == RFG_WR_WORD) m[ix | 1] = wr_data[15:8];
      @(negedge clk);
   endtask : wr
   // a read issued right after a write must see the new value
   task automatic rd(input int a, b, input logic w);
      wr_mode = RFG_WR_NONE;
      rd_a_idx = 5'(a);
      rd_b_idx = 5'(b);
      rd_word = w;
      @(negedge clk);
      chk(rd_a_data, m[a]);
      chk(rd_b_data, m[b]);
      chk(rd_word_data, w ? {m[a | 1], m[a & 30]} : 16'h0);
   endtask : rd
   task automatic ptr(input int s, k, input logic pg);
      logic [15:0] p;
      logic [15:0] a;
      ptr_disp = 6'($urandom);
      p = pv(pg ? 2 : s);
      a = k == 3 ? p - 16'h1 : k == 1 ? p + {10'h0, ptr_disp} : p;
      ptr_req = !pg;
      prog_req = pg;
      ptr_sel = rfg_ptr_sel_t'(s);
      ptr_mode = rfg_addr_mode_t'(k);
      @(negedge clk);
      ptr_req = 1'b0;
      prog_req = 1'b0;
      chk(addr_out, a);
      chk({addr_valid, addr_is_prog}, {1'b1, pg});
      p = k == 2 ? p + 16'h1 : k == 3 ? a : p;
      if (!pg) {m[27 + 2 * s], m[26 + 2 * s]} = p;
      @(negedge clk);
   endtask : ptr
   // low byte always goes first, then the high byte; nothing cuts in
   // between the two halves, as masked interrupts would ensure
   task automatic pio(input logic w, input logic [7:0] lo, hi);
      pio_wr = w;
      pio_rd = !w;
      pio_hi = 1'b0;
      pio_wdata = lo;
      upd = !w; // live value changes between the two byte reads
      upd_val = {hi, lo};
      @(negedge clk);
      upd = 1'b0;
      pio_hi = 1'b1;
      pio_wdata = hi;
      if (!w) chk(pio_rdata, pexp[7:0]);
      @(negedge clk);
      pio_wr = 1'b0;
      pio_rd = 1'b0;
      chk(pio_commit, w);
      chk(w ? pio_commit_data : {8'h0, pio_rdata}, w ? {hi, lo} : pexp >> 8);
      pexp = {hi, lo};
      // idle cycle: a commit lands in the model before the next read,
      // and no strobe is lowered and raised in one time step
      @(negedge clk);
   endtask : pio
   task automatic key(input logic [7:0] d, g);
      key_wr = 1'b1;
      key_data = d;
      @(negedge clk);
      key_wr = 1'b0;
      @(negedge clk);
      chk(config_change_guard, g);
      chk({self_program_unlock, io_unprotect_key}, g[1:0]);
   endtask : key
   // pulse one event: 0 io write, 1 nvm, 2 sleep, 3 retired instruction
   // event 0 stands for the protected write, enable bit set with its
   // data in that same write
   task automatic ev(input int e, input logic [7:0] g);
      irq_pending = 1'($urandom); // request level drawn at random
      {io_or_mem_wr, nvm_access, sleep_exec, insn_done} = 4'b1000 >> e;
      @(negedge clk);
      {io_or_mem_wr, nvm_access, sleep_exec, insn_done} = 4'h0;
      @(negedge clk);
      chk(config_change_guard, g);
      chk(irq_take_ok, g == 8'h0 && irq_pending);
   endtask : ev
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rd_a_idx, rd_b_idx, wr_idx, wr_data, upd_val} = 47'h0;
      {rd_word, ptr_req, prog_req, pio_wr, pio_rd, pio_hi, tmp_wr} = 7'h0;
      {tmp_rd, key_wr, insn_done, io_or_mem_wr, nvm_access} = 5'h0;
      {sleep_exec, upd, pio_wdata, key_data, ptr_disp, pexp} = 40'h0;
      irq_pending = 1'b1;
      wr_mode = RFG_WR_NONE;
      ptr_sel = RFG_PTR_X;
      ptr_mode = RFG_AM_PLAIN;
      foreach (m[i]) m[i] = 8'h00;
      void'($urandom(32'h0498));
      repeat (10) @(negedge clk);
      rst = 1'b0;
      rd(5, 26, 1'b1);
      for (int i = 0; i < 32; i++) wr(RFG_WR_BYTE, i);
      for (int i = 0; i < 32; i++) rd(i, 31 - i, 1'b0);
      wr(RFG_WR_WORD, 29);
      rd(29, 28, 1'b1);
      $display("test register file done");
      for (int k = 0; k < 4; k++) for (int s = 0; s < 3; s++) begin
         ptr(s, k, 1'b0);
         rd(26 + 2 * s, 27 + 2 * s, 1'b1);
      end
      ptr(0, 0, 1'b1);
      $display("test pointers done");
      repeat (4) pio($urandom % 2, 8'($urandom), 8'($urandom));
      // corner: a read straight after a write sees the committed word
      pio(1'b1, 8'h34, 8'h12);
      pio(1'b0, 8'hcd, 8'hab);
      tmp_wr = 1'b1;
      pio_wdata = 8'h5a;
      @(negedge clk);
      tmp_wr = 1'b0;
      tmp_rd = 1'b1;
      @(negedge clk);
      tmp_rd = 1'b0;
      chk(pio_rdata, 8'h5a);
      $display("test temp byte done");
      key(SIG_IO, 8'h01);
      for (int i = 1; i < 5; i++) ev(3, i < 4 ? 8'h01 : 8'h00);
      // each kill event is tried against a freshly opened io window
      for (int e = 0; e < 3; e++) begin
         key(SIG_IO, 8'h01);
         ev(e, 8'h00);
      end
      key(SIG_SELF_PROG, 8'h02);
      ev(0, 8'h02);
      ev(1, 8'h00);
      key(SIG_SELF_PROG, 8'h02);
      ev(2, 8'h00);
      // self-program window also runs out after four instructions
      key(SIG_SELF_PROG, 8'h02);
      for (int i = 1; i < 5; i++) ev(3, i < 4 ? 8'h02 : 8'h00);
      // 0x9c or 0x9b: never one of the two signatures
      key(8'h9c - 8'($urandom % 2), 8'h00);
      $display("test guard done");
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb_top
